// ### shared/awc_pkg.sv
// Constants, types and code tables for the alarm and warning code outputs
`default_nettype none
package awc_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    // Power-on alarm pulse, in milliseconds and in divider ticks
    localparam int PWRON_MS = 2000;
    localparam int PWRON_TICKS = PWRON_MS * (1_000_000 / TICK_NS);
    localparam int SYNC_STAGES = 3;
    localparam int N_ALARM = 7;

    // Alarm sources, lower index wins when several are latched
    typedef enum logic [2:0] {
        AL_REGEN = 3'h0,
        AL_OVVOLT = 3'h1,
        AL_UNDVOLT = 3'h2,
        AL_OVL_HI = 3'h3,
        AL_OVL_LO = 3'h4,
        AL_ENC_BKUP = 3'h5,
        AL_SYSTEM = 3'h6
    } awc_alarm_t;

    // Alarms that only a power cycle clears
    localparam logic [N_ALARM-1:0] STICKY_MASK = 7'h60;
    localparam logic [N_ALARM-1:0] ARM_RST = 7'h00;

    // Code output patterns, bit k set means output k conducts
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_WARN_OVL = 3'h1;
    localparam logic [2:0] CODE_WARN_REGEN = 3'h2;
    localparam logic [2:0] CODE_REGEN = 3'h1;
    localparam logic [2:0] CODE_VOLT = 3'h4;
    localparam logic [2:0] CODE_OVL = 3'h7;
    localparam logic [2:0] CODE_ENC = 3'h0;

    // Display numbers shown beside the codes
    localparam logic [7:0] DISP_NONE = 8'h00;
    localparam logic [7:0] DISP_REGEN = 8'h32;
    localparam logic [7:0] DISP_OVVOLT = 8'h40;
    localparam logic [7:0] DISP_UNDVOLT = 8'h41;
    localparam logic [7:0] DISP_OVL_HI = 8'h71;
    localparam logic [7:0] DISP_OVL_LO = 8'h72;
    localparam logic [7:0] DISP_ENC_BKUP = 8'h81;
    localparam logic [7:0] DISP_SYSTEM = 8'hBF;
    localparam logic [7:0] DISP_WARN_OVL = 8'h91;
    localparam logic [7:0] DISP_WARN_REGEN = 8'h92;

    // Code pattern of an alarm source
    function automatic logic [2:0] alarm_code(input awc_alarm_t a);
        unique case (a)
            AL_REGEN: alarm_code = CODE_REGEN;
            AL_OVVOLT, AL_UNDVOLT: alarm_code = CODE_VOLT;
            AL_OVL_HI, AL_OVL_LO: alarm_code = CODE_OVL;
            AL_ENC_BKUP, AL_SYSTEM: alarm_code = CODE_ENC;
            default: alarm_code = CODE_NONE;
        endcase
    endfunction

    // Display number; large units fold undervoltage into the voltage alarm
    function automatic logic [7:0] alarm_disp(input awc_alarm_t a, input logic high_cap);
        unique case (a)
            AL_REGEN: alarm_disp = DISP_REGEN;
            AL_OVVOLT: alarm_disp = DISP_OVVOLT;
            AL_UNDVOLT: alarm_disp = high_cap ? DISP_OVVOLT : DISP_UNDVOLT; // [RULE9]
            AL_OVL_HI: alarm_disp = DISP_OVL_HI;
            AL_OVL_LO: alarm_disp = DISP_OVL_LO;
            AL_ENC_BKUP: alarm_disp = DISP_ENC_BKUP;
            AL_SYSTEM: alarm_disp = DISP_SYSTEM;
            default: alarm_disp = DISP_NONE;
        endcase
    endfunction
endpackage
`default_nettype wire

// ### shared/awc_if.sv
// Link between the code-output control and the alarm latch bank
`default_nettype none
interface awc_if;
    import awc_pkg::*;
    logic [N_ALARM-1:0] det;
    logic [N_ALARM-1:0] arm;
    logic clr;
    logic [N_ALARM-1:0] latched;
    modport ctrl (output det, output arm, output clr, input latched);
    modport bank (input det, input arm, input clr, output latched);
endinterface
`default_nettype wire

// ### hdl/awc_latch.sv
// Alarm latch bank with power-cycle-only alarms
`default_nettype none
module awc_latch (
    input wire logic clk_i,
    input wire logic rst_i,
    awc_if.bank lk
);
    import awc_pkg::*;

    typedef struct packed {
        logic [N_ALARM-1:0] lat;
    } awc_latch_st_t;

    awc_latch_st_t q;
    awc_latch_st_t d;

    ////////////////////////////////////////////////////////////////////////
    // Next state: a detection in the clear cycle still latches
    always_comb begin
        d = q;
        if (lk.clr) begin
            d.lat = q.lat & STICKY_MASK; // [RULE5]
        end
        d.lat = d.lat | (lk.det & lk.arm);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lk.latched = q.lat;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_sticky_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
        (lk.clr && (q.lat[AL_ENC_BKUP])) |=> q.lat[AL_ENC_BKUP])
        else $error("sticky alarm cleared by alarm reset");
    a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        (lk.clr && lk.det[AL_OVVOLT] && lk.arm[AL_OVVOLT]) |=> q.lat[AL_OVVOLT])
        else $error("alarm lost in clear cycle");
    a_clear_works: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
        (lk.clr && !lk.det[AL_OVVOLT]) |=> !q.lat[AL_OVVOLT])
        else $error("resettable alarm not cleared");
endmodule
`default_nettype wire

// ### hdl/awc_top.sv
// Alarm and warning code outputs of the amplifier fault logic
// Function
// [RULE1] Overload warning on bit0, regenerative on bit1
// [RULE2] Active code output pulls its line low
// [RULE3] Overload warning precedes overload alarms
// [RULE4] Regenerative warning precedes regenerative alarm
// [RULE5] Some alarms clear only by power cycle
// [RULE6] Fault output asserted two seconds at power-on
// [RULE7] Host tolerates the start-up fault pulse
// [RULE8] Host drives fault relay from fault output
// [RULE9] Large units report undervoltage as voltage alarm
// [RULE10] Warning code held while condition persists
`default_nettype none
module awc_top #(
    parameter int TICK_CYC_P = awc_pkg::TICK_CYC,
    parameter int PWRON_TICKS_P = awc_pkg::PWRON_TICKS,
    parameter bit HIGH_CAP = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [awc_pkg::N_ALARM-1:0] alarm_det_i,
    input wire logic warn_ovl_i,
    input wire logic warn_regen_i,
    input wire logic fault_clear_n_i,
    output logic code_out_bit0_o,
    output logic code_out_bit0_oe_o,
    output logic code_out_bit1_o,
    output logic code_out_bit1_oe_o,
    output logic code_out_bit2_o,
    output logic code_out_bit2_oe_o,
    output logic fault_out_o,
    output logic fault_out_oe_o,
    output logic [7:0] alarm_disp_o
);
    import awc_pkg::*;

    localparam int TW = $clog2(TICK_CYC_P + 1);
    localparam int PW = $clog2(PWRON_TICKS_P + 1);

    // Counters are sized from these, so zero would never end
    if (TICK_CYC_P < 1 || PWRON_TICKS_P < 1) begin : g_bad_param
        $error("awc_top: counts must be at least one");
    end

    typedef enum logic [0:0] {
        ST_POWERON = 1'b0,
        ST_RUN = 1'b1
    } awc_state_t;

    typedef struct packed {
        awc_state_t st;
        logic [TW-1:0] div;
        logic tick;
        logic [PW-1:0] pw;
        logic [SYNC_STAGES-1:0] sync;
        logic clr_lvl_n;
        logic clr;
        logic ovl_seen;
        logic regen_seen;
        logic [2:0] code;
        logic fault;
        logic [7:0] disp;
    } awc_top_st_t;

    awc_top_st_t q;
    awc_top_st_t d;
    awc_if lk ();

    ////////////////////////////////////////////////////////////////////////
    // Alarm latch bank
    awc_latch u_latch (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .lk (lk.bank)
    );

    // Overload and regenerative alarms may latch only once the matching warning has shown
    always_comb begin
        lk.det = alarm_det_i;
        lk.clr = q.clr;
        lk.arm = '1;
        lk.arm[AL_OVL_HI] = q.ovl_seen; // [RULE3]
        lk.arm[AL_OVL_LO] = q.ovl_seen; // [RULE3]
        lk.arm[AL_REGEN] = q.regen_seen; // [RULE4]
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        d = q;
        d.clr = 1'b0;

        // Millisecond enable from the clock divider
        d.tick = 1'b0;
        if (q.div == TW'(TICK_CYC_P - 1)) begin
            d.div = '0;
            d.tick = 1'b1;
        end else begin
            d.div = q.div + TW'(1);
        end

        // Pin synchroniser; a change counts once the last two stages agree
        d.sync = {q.sync[SYNC_STAGES-2:0], fault_clear_n_i};
        if (q.sync[1] == q.sync[2]) begin
            d.clr_lvl_n = q.sync[2];
            // Clear fires once, on the falling edge of the filtered level
            d.clr = q.clr_lvl_n & ~q.sync[2];
        end

        // Warning history; dropped on clear once the warning has gone
        if (warn_ovl_i) begin
            d.ovl_seen = 1'b1;
        end else if (q.clr) begin
            d.ovl_seen = 1'b0;
        end
        if (warn_regen_i) begin
            d.regen_seen = 1'b1;
        end else if (q.clr) begin
            d.regen_seen = 1'b0;
        end

        unique case (q.st)
            // Fault held asserted while the start-up pulse runs
            ST_POWERON: begin
                d.fault = 1'b1; // [RULE6]
                d.code = CODE_NONE;
                d.disp = DISP_NONE;
                if (q.tick) begin
                    d.pw = q.pw + PW'(1);
                    if (q.pw == PW'(PWRON_TICKS_P - 1)) begin
                        d.st = ST_RUN;
                    end
                end
            end
            // Alarms beat warnings; warnings show only while present
            ST_RUN: begin
                d.fault = 1'b0;
                d.code = CODE_NONE; // [RULE10]
                d.disp = DISP_NONE;
                if (warn_ovl_i) begin
                    d.code = CODE_WARN_OVL; // [RULE1]
                    d.disp = DISP_WARN_OVL;
                end else if (warn_regen_i) begin
                    d.code = CODE_WARN_REGEN; // [RULE1]
                    d.disp = DISP_WARN_REGEN;
                end
                for (int i = N_ALARM - 1; i >= 0; i--) begin
                    if (lk.latched[i]) begin
                        d.fault = 1'b1;
                        d.code = alarm_code(awc_alarm_t'(i[2:0]));
                        d.disp = alarm_disp(awc_alarm_t'(i[2:0]), HIGH_CAP); // [RULE9]
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{st: ST_POWERON, div: '0, tick: 1'b0, pw: '0, sync: '1,
                   clr_lvl_n: 1'b1, clr: 1'b0, ovl_seen: 1'b0, regen_seen: 1'b0,
                   code: CODE_NONE, fault: 1'b1, disp: DISP_NONE};
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open-collector pins: value is always low, enable conducts
    assign code_out_bit0_o = 1'b0; // [RULE2]
    assign code_out_bit1_o = 1'b0; // [RULE2]
    assign code_out_bit2_o = 1'b0; // [RULE2]
    assign fault_out_o = 1'b0;
    assign code_out_bit0_oe_o = q.code[0]; // [RULE2]
    assign code_out_bit1_oe_o = q.code[1]; // [RULE2]
    assign code_out_bit2_oe_o = q.code[2]; // [RULE2]
    // Transistor off when a fault is up, so a broken wire also reads as fault
    assign fault_out_oe_o = ~q.fault; // [RULE8]
    assign alarm_disp_o = q.disp;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [PW:0] chk_pw_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chk_pw_q <= '0;
        end else if (q.st == ST_POWERON && q.tick) begin
            chk_pw_q <= chk_pw_q + (PW+1)'(1);
        end
    end

    a_poweron_fault: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
        (q.st == ST_POWERON) |-> !fault_out_oe_o)
        else $error("fault output not asserted during power-on");
    a_poweron_len: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
        (q.st == ST_RUN) |-> (chk_pw_q == (PW+1)'(PWRON_TICKS_P)))
        else $error("power-on pulse length wrong");
    a_warn_ovl_code: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
        (q.st == ST_RUN && lk.latched == '0 && warn_ovl_i)
        |=> ({code_out_bit2_oe_o, code_out_bit1_oe_o, code_out_bit0_oe_o} == 3'h1)
            && fault_out_oe_o)
        else $error("overload warning code wrong");
    a_warn_regen_code: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
        (q.st == ST_RUN && lk.latched == '0 && !warn_ovl_i && warn_regen_i)
        |=> {code_out_bit2_oe_o, code_out_bit1_oe_o, code_out_bit0_oe_o} == 3'h2)
        else $error("regenerative warning code wrong");
    a_warn_release: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
        (q.st == ST_RUN && lk.latched == '0 && !warn_ovl_i && !warn_regen_i)
        |=> !code_out_bit0_oe_o && !code_out_bit1_oe_o && !code_out_bit2_oe_o)
        else $error("code outputs not released");
    a_lines_low: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
        !code_out_bit0_o && !code_out_bit1_o && !code_out_bit2_o)
        else $error("code output driven high");
    a_ovl_after_warn: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
        $rose(lk.latched[AL_OVL_HI]) |-> $past(q.ovl_seen))
        else $error("overload alarm without prior warning");
    a_regen_after_warn: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
        $rose(lk.latched[AL_REGEN]) |-> $past(q.regen_seen))
        else $error("regenerative alarm without prior warning");
    a_undervolt_code: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
        HIGH_CAP |-> (alarm_disp_o != DISP_UNDVOLT))
        else $error("undervoltage number used on a large unit");
endmodule
`default_nettype wire

// ### sim/awc_host_model.sv
// Host controller model that reads the open-collector status lines
`default_nettype none
module awc_host_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] code_oe_i,
    input wire logic [2:0] code_pin_i,
    input wire logic fault_oe_i,
    input wire logic fault_pin_i,
    input wire logic clear_req_i,
    output logic [2:0] code_line_o,
    output logic fault_line_o,
    output logic fault_relay_o,
    output logic genuine_fault_o,
    output logic fault_clear_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen_ready_q;
    // Pull-ups hold each line high unless its transistor conducts
    // A conducting transistor shows the pin value, so a pin driven high would be seen
    assign code_line_o = (code_oe_i & code_pin_i) | ~code_oe_i;
    assign fault_line_o = fault_oe_i ? fault_pin_i : 1'b1;
    // Relay drops main power whenever the fault line is asserted
    assign fault_relay_o = fault_line_o;
    // Start-up pulse is not a fault: only count faults once normal was seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_ready_q <= 1'b0;
        end else if (!fault_line_o) begin
            seen_ready_q <= 1'b1;
        end
    end
    assign genuine_fault_o = seen_ready_q & fault_line_o;
    // Clear pin is active low at the amplifier
    assign fault_clear_n_o = ~clear_req_i;
endmodule
`default_nettype wire

// ### sim/awc_top_tb_top.sv
// Self-checking bench for the alarm and warning code outputs
`default_nettype none
module awc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import awc_pkg::*;
    localparam int TCYC = 4;
    localparam int TICKS = 3;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [N_ALARM-1:0] det = '0;
    logic wovl = 1'b0;
    logic wreg = 1'b0;
    logic clear_req = 1'b0;
    logic clr_n;
    logic [2:0] oe;
    logic [2:0] pin;
    logic foe;
    logic fpin;
    logic [7:0] disp;
    logic [7:0] disp_lo;
    logic [2:0] code_line;
    logic fault_line;
    logic relay;
    logic genuine;
    int miscompares = 0;
    int cmp_count = 0;
    ////////////////////////////////////////////////////////////////
    // Clock, design and host
    always #12.5 clk_i = ~clk_i;
    awc_top #(.TICK_CYC_P(TCYC), .PWRON_TICKS_P(TICKS), .HIGH_CAP(1'b1)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .alarm_det_i(det), .warn_ovl_i(wovl),
        .warn_regen_i(wreg), .fault_clear_n_i(clr_n),
        .code_out_bit0_o(pin[0]), .code_out_bit0_oe_o(oe[0]),
        .code_out_bit1_o(pin[1]), .code_out_bit1_oe_o(oe[1]),
        .code_out_bit2_o(pin[2]), .code_out_bit2_oe_o(oe[2]),
        .fault_out_o(fpin), .fault_out_oe_o(foe), .alarm_disp_o(disp));
    // Smaller unit on the same stimulus keeps its own undervoltage number
    awc_top #(.TICK_CYC_P(TCYC), .PWRON_TICKS_P(TICKS), .HIGH_CAP(1'b0)) dut_lo_u (
        .clk_i(clk_i), .rst_i(rst_i), .alarm_det_i(det), .warn_ovl_i(wovl),
        .warn_regen_i(wreg), .fault_clear_n_i(clr_n),
        .code_out_bit0_o(), .code_out_bit0_oe_o(),
        .code_out_bit1_o(), .code_out_bit1_oe_o(),
        .code_out_bit2_o(), .code_out_bit2_oe_o(),
        .fault_out_o(), .fault_out_oe_o(), .alarm_disp_o(disp_lo));
    awc_host_model hm_u (
        .clk_i(clk_i), .rst_i(rst_i), .code_oe_i(oe), .code_pin_i(pin), .fault_oe_i(foe),
        .fault_pin_i(fpin), .clear_req_i(clear_req), .code_line_o(code_line),
        .fault_line_o(fault_line), .fault_relay_o(relay), .genuine_fault_o(genuine),
        .fault_clear_n_o(clr_n));
    ////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Line levels are the inverse of the code, conducting means low
    task automatic status(input logic [2:0] code, input logic flt, input logic [7:0] dsp);
        chk("code lines", {5'h00, ~code}, {5'h00, code_line});
        chk("fault line", {7'h00, flt}, {7'h00, fault_line});
        chk("display", dsp, disp);
    endtask
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_poweron();
        int n;
        logic ok;
        rst_i = 1'b1;
        cyc(8);
        status(CODE_NONE, 1'b1, DISP_NONE);
        rst_i = 1'b0;
        cyc(6);
        status(CODE_NONE, 1'b1, DISP_NONE);
        // Checked while the start-up pulse is still up
        chk("pulse not genuine", 8'h00, {7'h00, genuine});
        n = 6;
        while (fault_line === 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        // Pulse length allows for tick and output register slack
        ok = (n >= TICKS * TCYC - 2) && (n <= TICKS * TCYC + 4);
        chk("pulse ok", 8'h01, {7'h00, ok});
        chk("host tolerates", 8'h00, {7'h00, genuine});
    endtask
    // Overload and regen alarms without warning history are ignored
    task automatic t_gate(input awc_alarm_t a);
        det[a] = 1'b1;
        cyc(1);
        det = '0;
        cyc(3);
        status(CODE_NONE, 1'b0, DISP_NONE);
    endtask
    task automatic t_warn(input logic o, input logic r, input logic [2:0] c, input logic [7:0] d);
        wovl = o;
        wreg = r;
        cyc(2);
        status(c, 1'b0, d);
        cyc(5);
        status(c, 1'b0, d);
        wovl = 1'b0;
        wreg = 1'b0;
        cyc(2);
        status(CODE_NONE, 1'b0, DISP_NONE);
    endtask
    task automatic t_alarm(input awc_alarm_t a, input logic o, input logic r,
                           input logic [2:0] c, input logic [7:0] d,
                           input logic [7:0] d_lo, input logic sticky);
        wovl = o;
        wreg = r;
        cyc(3);
        det[a] = 1'b1;
        cyc(1);
        det = '0;
        cyc(3);
        status(c, 1'b1, d);
        chk("small unit display", d_lo, disp_lo);
        chk("relay", 8'h01, {7'h00, relay});
        chk("genuine fault", 8'h01, {7'h00, genuine});
        wovl = 1'b0;
        wreg = 1'b0;
        cyc(3);
        status(c, 1'b1, d);
        clear_req = 1'b1;
        cyc(6);
        clear_req = 1'b0;
        cyc(4);
        // Sticky alarms survive the clear pin
        if (sticky) status(c, 1'b1, d);
        else status(CODE_NONE, 1'b0, DISP_NONE);
    endtask
    // Detection in the very cycle of the clear pulse must still latch
    task automatic t_clear_race();
        clear_req = 1'b1;
        cyc(4);
        det[AL_OVVOLT] = 1'b1;
        cyc(1);
        det = '0;
        clear_req = 1'b0;
        cyc(5);
        status(CODE_VOLT, 1'b1, DISP_OVVOLT);
        clear_req = 1'b1;
        cyc(6);
        clear_req = 1'b0;
        cyc(4);
        status(CODE_NONE, 1'b0, DISP_NONE);
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    task automatic final_report();
        $display("cmp_count=%0d miscompares=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Whole sequence takes a few hundred cycles; 3000 leaves ample margin
    initial begin
        #(25 * 3000);
        miscompares++;
        final_report();
    end
    initial begin
        t_poweron();
        t_gate(AL_OVL_HI);
        t_gate(AL_OVL_LO);
        t_gate(AL_REGEN);
        t_warn(1'b1, 1'b0, CODE_WARN_OVL, DISP_WARN_OVL);
        t_warn(1'b0, 1'b1, CODE_WARN_REGEN, DISP_WARN_REGEN);
        t_warn(1'b1, 1'b1, CODE_WARN_OVL, DISP_WARN_OVL);
        t_alarm(AL_OVL_HI, 1'b1, 1'b0, CODE_OVL, DISP_OVL_HI, DISP_OVL_HI, 1'b0);
        t_alarm(AL_OVL_LO, 1'b1, 1'b0, CODE_OVL, DISP_OVL_LO, DISP_OVL_LO, 1'b0);
        t_alarm(AL_REGEN, 1'b0, 1'b1, CODE_REGEN, DISP_REGEN, DISP_REGEN, 1'b0);
        t_alarm(AL_UNDVOLT, 1'b0, 1'b0, CODE_VOLT, DISP_OVVOLT, DISP_UNDVOLT, 1'b0);
        t_alarm(AL_OVVOLT, 1'b0, 1'b0, CODE_VOLT, DISP_OVVOLT, DISP_OVVOLT, 1'b0);
        t_clear_race();
        t_alarm(AL_ENC_BKUP, 1'b0, 1'b0, CODE_ENC, DISP_ENC_BKUP, DISP_ENC_BKUP, 1'b1);
        t_poweron();
        status(CODE_NONE, 1'b0, DISP_NONE);
        t_alarm(AL_SYSTEM, 1'b0, 1'b0, CODE_ENC, DISP_SYSTEM, DISP_SYSTEM, 1'b1);
        t_poweron();
        status(CODE_NONE, 1'b0, DISP_NONE);
        final_report();
    end
endmodule
`default_nettype wire
